//--- hw/bmph_pkg.sv
// package: message codes, extended layout constants, parser states and opcode types
package bmph_pkg;
    localparam logic [7:0] MSG_ABORT = 8'h06;
    localparam logic [7:0] MSG_BUS_DEV_RESET = 8'h0C;
    localparam logic [7:0] MSG_EXTENDED = 8'h01;
    localparam logic [7:0] TWO_BYTE_LO = 8'h20;
    localparam logic [7:0] TWO_BYTE_HI = 8'h2F;
    localparam int IDENT_BIT = 7;
    localparam int LUNTAR_BIT = 5;
    localparam int LUN_HI = 2;
    localparam int LUN_LO = 0;
    localparam logic [7:0] XCODE_MODIFY_PTR = 8'h00;
    localparam logic [7:0] XCODE_SYNC_REQ = 8'h01;
    localparam logic [7:0] XCODE_RESERVED_02 = 8'h02;
    localparam logic [7:0] XCODE_WIDE_REQ = 8'h03;
    localparam logic [7:0] XCODE_VENDOR_LO = 8'h80;
    localparam int EXT_MIN_BYTES = 3;
    localparam logic [8:0] EXT_ZERO_LEN = 9'h100;
    localparam int EXT_LEN_W = 9;

    typedef enum {
        BMPH_IDLE,
        BMPH_SECOND,
        BMPH_EXT_LEN,
        BMPH_EXT_CODE,
        BMPH_EXT_ARGS
    } bmph_state_t;

    typedef enum logic [2:0] {
        BMPH_X_NONE,
        BMPH_X_MODIFY_PTR,
        BMPH_X_SYNC_REQ,
        BMPH_X_WIDE_REQ,
        BMPH_X_RESERVED,
        BMPH_X_VENDOR
    } bmph_xcode_t;
endpackage

//--- hw/bmph_nexus_if.sv
// interface: parser to nexus tracker connection
`timescale 1ns/100ps
interface bmph_nexus_if;
    logic ident_pulse;
    logic [3:0] ident_unit;
    logic first_msg;
    logic clear_nexus;
    logic nexus_valid;
    logic [3:0] nexus_unit;
    logic unit_mismatch;
    modport parser (
        output ident_pulse,
        output ident_unit,
        output clear_nexus,
        input first_msg,
        input nexus_valid,
        input nexus_unit,
        input unit_mismatch
    );
    modport tracker (
        input ident_pulse,
        input ident_unit,
        input clear_nexus,
        output first_msg,
        output nexus_valid,
        output nexus_unit,
        output unit_mismatch
    );
endinterface

//--- hw/bmph_nexus.sv
// nexus tracker: first-message flag and identified unit per connection
`timescale 1ns/100ps
module bmph_nexus (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic conn_start,
    bmph_nexus_if.tracker nx
);
    logic first_q, first_d;
    logic valid_q, valid_d;
    logic [3:0] unit_q, unit_d;

    always_comb begin
        first_d = first_q;
        valid_d = valid_q;
        unit_d = unit_q;
        if (conn_start) begin
            first_d = 1'b1;
            valid_d = 1'b0;
        end else if (nx.clear_nexus) begin
            first_d = 1'b0;
            valid_d = 1'b0;
        end else if (nx.ident_pulse) begin
            first_d = 1'b0;
            // first unit named sticks; a different one is reported, never adopted
            if (!valid_q) begin
                valid_d = 1'b1;
                unit_d = nx.ident_unit;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            first_q <= 1'b0;
            valid_q <= 1'b0;
            unit_q <= 4'h0;
        end else begin
            first_q <= first_d;
            valid_q <= valid_d;
            unit_q <= unit_d;
        end
    end

    assign nx.first_msg = first_q;
    assign nx.nexus_valid = valid_q;
    assign nx.nexus_unit = unit_q;
    // independent of ident_pulse so the parser can read it without a loop back into itself
    assign nx.unit_mismatch = valid_q && (nx.ident_unit != unit_q);
endmodule

//--- hw/bmph_top.sv
// target-side message phase parser: extended layout, opening checks, abort handling
`timescale 1ns/100ps
module bmph_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sel_start,
    input wire logic resel_start,
    input wire logic msg_phase,
    input wire logic msg_valid,
    input wire logic [7:0] msg_byte,
    input wire logic [3:0] own_unit,
    output logic bus_free_req,
    output logic unexpected_disc,
    output logic abort_nexus,
    output logic [3:0] abort_unit,
    output logic ident_in_valid,
    output logic [7:0] ident_in_byte,
    output logic msg_done,
    output logic [7:0] msg_code,
    output logic [7:0] msg_param,
    output logic ext_done,
    output logic [7:0] ext_code,
    output bmph_pkg::bmph_xcode_t ext_kind,
    output logic [8:0] ext_len,
    output logic arg_valid,
    output logic [7:0] arg_byte,
    output logic nexus_valid,
    output logic [3:0] nexus_unit
);
    bmph_nexus_if nx ();

    bmph_nexus u_nexus (
        .clk(clk),
        .arst_n(arst_n),
        .conn_start(sel_start),
        .nx(nx)
    );

    bmph_pkg::bmph_state_t st_q, st_d;
    logic [8:0] cnt_q, cnt_d;
    logic [8:0] len_q, len_d;
    logic [7:0] code_q, code_d;
    logic [7:0] param_q, param_d;
    logic [7:0] xcode_q, xcode_d;
    bmph_pkg::bmph_xcode_t kind_q, kind_d;
    logic done_q, done_d;
    logic xdone_q, xdone_d;
    logic free_q, free_d;
    logic unexp_q, unexp_d;
    logic abort_q, abort_d;
    logic [3:0] aunit_q, aunit_d;
    logic argv_q, argv_d;
    logic [7:0] arg_q, arg_d;
    logic idv_q, idv_d;
    logic [7:0] idb_q, idb_d;
    logic is_ident;
    logic opening_ok;
    logic ext_min_ok;
    logic [1:0] xseen_q, xseen_d;

    assign is_ident = msg_byte[bmph_pkg::IDENT_BIT];
    assign opening_ok = is_ident || msg_byte == bmph_pkg::MSG_ABORT
        || msg_byte == bmph_pkg::MSG_BUS_DEV_RESET;
    assign nx.ident_unit = {msg_byte[bmph_pkg::LUNTAR_BIT],
        msg_byte[bmph_pkg::LUN_HI:bmph_pkg::LUN_LO]};
    assign ext_min_ok = int'({1'b0, xseen_q} + 3'h1) >= bmph_pkg::EXT_MIN_BYTES;

    function automatic bmph_pkg::bmph_xcode_t decode_x(input logic [7:0] c);
        if (c == bmph_pkg::XCODE_MODIFY_PTR) begin
            decode_x = bmph_pkg::BMPH_X_MODIFY_PTR;
        end else if (c == bmph_pkg::XCODE_SYNC_REQ) begin
            decode_x = bmph_pkg::BMPH_X_SYNC_REQ;
        end else if (c == bmph_pkg::XCODE_WIDE_REQ) begin
            decode_x = bmph_pkg::BMPH_X_WIDE_REQ;
        end else if (c >= bmph_pkg::XCODE_VENDOR_LO) begin
            decode_x = bmph_pkg::BMPH_X_VENDOR;
        end else begin
            decode_x = bmph_pkg::BMPH_X_RESERVED;
        end
    endfunction

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        len_d = len_q;
        code_d = code_q;
        param_d = param_q;
        xcode_d = xcode_q;
        kind_d = kind_q;
        done_d = 1'b0;
        xdone_d = 1'b0;
        free_d = 1'b0;
        unexp_d = 1'b0;
        abort_d = 1'b0;
        aunit_d = aunit_q;
        argv_d = 1'b0;
        arg_d = arg_q;
        nx.ident_pulse = 1'b0;
        nx.clear_nexus = 1'b0;
        if (sel_start || !msg_phase) begin
            // leaving the phase drops any partial message
            st_d = bmph_pkg::BMPH_IDLE;
        end else if (msg_valid) begin
            unique case (st_q)
                bmph_pkg::BMPH_IDLE: begin
                    code_d = msg_byte;
                    if (nx.first_msg && !opening_ok) begin
                        free_d = 1'b1;
                        unexp_d = 1'b1;
                        nx.clear_nexus = 1'b1;
                    end else if (is_ident) begin
                        nx.ident_pulse = 1'b1;
                        done_d = !nx.unit_mismatch;
                        if (nx.unit_mismatch) begin
                            free_d = 1'b1;
                            unexp_d = 1'b1;
                            nx.clear_nexus = 1'b1;
                        end
                    end else if (msg_byte == bmph_pkg::MSG_ABORT) begin
                        // only the nexus's own processes; mode state lives elsewhere
                        abort_d = nx.nexus_valid;
                        aunit_d = nx.nexus_unit;
                        free_d = 1'b1;
                        done_d = 1'b1;
                        nx.clear_nexus = 1'b1;
                    end else if (msg_byte == bmph_pkg::MSG_EXTENDED) begin
                        st_d = bmph_pkg::BMPH_EXT_LEN;
                        nx.clear_nexus = 1'b0;
                    end else if (msg_byte >= bmph_pkg::TWO_BYTE_LO
                        && msg_byte <= bmph_pkg::TWO_BYTE_HI) begin
                        st_d = bmph_pkg::BMPH_SECOND;
                    end else begin
                        done_d = 1'b1;
                        if (msg_byte == bmph_pkg::MSG_BUS_DEV_RESET) begin
                            free_d = 1'b1;
                            nx.clear_nexus = 1'b1;
                        end
                    end
                    if (nx.first_msg && opening_ok && !is_ident) begin
                        nx.clear_nexus = 1'b1;
                    end
                end
                bmph_pkg::BMPH_SECOND: begin
                    param_d = msg_byte;
                    done_d = 1'b1;
                    st_d = bmph_pkg::BMPH_IDLE;
                end
                bmph_pkg::BMPH_EXT_LEN: begin
                    // zero length means 256 bytes follow
                    len_d = msg_byte == 8'h00 ? bmph_pkg::EXT_ZERO_LEN :
                        {1'b0, msg_byte};
                    cnt_d = msg_byte == 8'h00 ? bmph_pkg::EXT_ZERO_LEN :
                        {1'b0, msg_byte};
                    st_d = bmph_pkg::BMPH_EXT_CODE;
                end
                bmph_pkg::BMPH_EXT_CODE: begin
                    xcode_d = msg_byte;
                    kind_d = decode_x(msg_byte);
                    cnt_d = cnt_q - 9'h001;
                    if (cnt_q == 9'h001 && ext_min_ok) begin
                        xdone_d = 1'b1;
                        done_d = 1'b1;
                        st_d = bmph_pkg::BMPH_IDLE;
                    end else begin
                        st_d = bmph_pkg::BMPH_EXT_ARGS;
                    end
                end
                bmph_pkg::BMPH_EXT_ARGS: begin
                    argv_d = 1'b1;
                    arg_d = msg_byte;
                    cnt_d = cnt_q - 9'h001;
                    if (cnt_q == 9'h001 && ext_min_ok) begin
                        xdone_d = 1'b1;
                        done_d = 1'b1;
                        st_d = bmph_pkg::BMPH_IDLE;
                    end
                end
                default: st_d = bmph_pkg::BMPH_IDLE;
            endcase
        end
        // our own reselection identify never changes the nexus
        if (resel_start) begin
            nx.ident_pulse = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= bmph_pkg::BMPH_IDLE;
            cnt_q <= 9'h000;
            len_q <= 9'h000;
            code_q <= 8'h00;
            param_q <= 8'h00;
            xcode_q <= 8'h00;
            kind_q <= bmph_pkg::BMPH_X_NONE;
            done_q <= 1'b0;
            xdone_q <= 1'b0;
            free_q <= 1'b0;
            unexp_q <= 1'b0;
            abort_q <= 1'b0;
            aunit_q <= 4'h0;
            argv_q <= 1'b0;
            arg_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            code_q <= code_d;
            param_q <= param_d;
            xcode_q <= xcode_d;
            kind_q <= kind_d;
            done_q <= done_d;
            xdone_q <= xdone_d;
            free_q <= free_d;
            unexp_q <= unexp_d;
            abort_q <= abort_d;
            aunit_q <= aunit_d;
            argv_q <= argv_d;
            arg_q <= arg_d;
        end
    end

    // reselection: announce own unit with identify first
    // separate group: the reply is built whatever the parser is doing
    always_comb begin
        idv_d = resel_start;
        idb_d = idb_q;
        if (resel_start) begin
            idb_d = {1'b1, 3'h0, own_unit};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idv_q <= 1'b0;
            idb_q <= 8'h00;
        end else begin
            idv_q <= idv_d;
            idb_q <= idb_d;
        end
    end

    // bytes seen of the current extended message, saturating at three
    // independent of the length count, so a wrapped count cannot end it early
    always_comb begin
        xseen_d = xseen_q;
        if (sel_start || !msg_phase) begin
            xseen_d = 2'h0;
        end else if (msg_valid) begin
            if (st_q == bmph_pkg::BMPH_IDLE) begin
                xseen_d = msg_byte == bmph_pkg::MSG_EXTENDED ? 2'h1 : 2'h0;
            end else if (xseen_q != 2'h3) begin
                xseen_d = xseen_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xseen_q <= 2'h0;
        end else begin
            xseen_q <= xseen_d;
        end
    end

    assign bus_free_req = free_q;
    assign unexpected_disc = unexp_q;
    assign abort_nexus = abort_q;
    assign abort_unit = aunit_q;
    assign ident_in_valid = idv_q;
    assign ident_in_byte = idb_q;
    assign msg_done = done_q;
    assign msg_code = code_q;
    assign msg_param = param_q;
    assign ext_done = xdone_q;
    assign ext_code = xcode_q;
    assign ext_kind = kind_q;
    assign ext_len = len_q;
    assign arg_valid = argv_q;
    assign arg_byte = arg_q;
    assign nexus_valid = nx.nexus_valid;
    assign nexus_unit = nx.nexus_unit;
endmodule

//--- verif/bmph_checker.sv
// checker: port-level properties of the message phase parser
`timescale 1ns/100ps
module bmph_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sel_start,
    input wire logic resel_start,
    input wire logic msg_phase,
    input wire logic msg_valid,
    input wire logic [7:0] msg_byte,
    input wire logic [3:0] own_unit,
    input wire logic bus_free_req,
    input wire logic unexpected_disc,
    input wire logic abort_nexus,
    input wire logic [3:0] abort_unit,
    input wire logic ident_in_valid,
    input wire logic [7:0] ident_in_byte,
    input wire logic msg_done,
    input wire logic [7:0] msg_code,
    input wire logic [7:0] msg_param,
    input wire logic ext_done,
    input wire logic [7:0] ext_code,
    input bmph_pkg::bmph_xcode_t ext_kind,
    input wire logic [8:0] ext_len,
    input wire logic arg_valid,
    input wire logic nexus_valid,
    input wire logic [3:0] nexus_unit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic tk;
    logic [8:0] args_q;
    logic [8:0] args_d;
    bmph_pkg::bmph_xcode_t xk;
    assign tk = msg_phase && msg_valid && !sel_start;
    // dropping the phase abandons a partial message, so its args must not leak into the next
    always_comb begin
        args_d = args_q + 9'(arg_valid);
        if (ext_done || !msg_phase) begin
            args_d = 9'h000;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            args_q <= 9'h000;
        end else begin
            args_q <= args_d;
        end
    end
    always_comb begin
        xk = bmph_pkg::BMPH_X_RESERVED;
        if (ext_code == bmph_pkg::XCODE_MODIFY_PTR) xk = bmph_pkg::BMPH_X_MODIFY_PTR;
        if (ext_code == bmph_pkg::XCODE_SYNC_REQ) xk = bmph_pkg::BMPH_X_SYNC_REQ;
        if (ext_code == bmph_pkg::XCODE_WIDE_REQ) xk = bmph_pkg::BMPH_X_WIDE_REQ;
        if (ext_code[7]) xk = bmph_pkg::BMPH_X_VENDOR;
    end
    AST_EXT_LEAD: assert property (ext_done |-> msg_done && msg_code == 8'h01)
        else $error("extended message without leading 01h");
    AST_EXT_KIND: assert property (ext_done |-> ext_kind == xk)
        else $error("extended code class wrong");
    AST_EXT_LEN: assert property (ext_done |-> ext_len != 9'h000 && ext_len <= 9'h100)
        else $error("extended length out of range");
    AST_EXT_SPAN: assert property (ext_done |-> args_q + 9'(arg_valid) == ext_len - 9'h001)
        else $error("argument count does not match length");
    AST_TWO_BYTE: assert property (msg_done && msg_code inside {[8'h20:8'h2F]} |->
        msg_param == $past(msg_byte)) else $error("two-byte parameter wrong");
    AST_BAD_FIRST: assert property (sel_start ##1 !msg_valid ##1 (tk && !msg_byte[7] &&
        msg_byte != 8'h06 && msg_byte != 8'h0C) |=> bus_free_req && unexpected_disc && !msg_done)
        else $error("bad opening message not dropped");
    AST_RESEL: assert property (resel_start |-> ##[1:2] ident_in_valid &&
        ident_in_byte == {4'h8, own_unit}) else $error("reselection identify missing");
    AST_ABORT: assert property (msg_done && nexus_valid && tk && msg_byte == 8'h06 |=>
        abort_nexus && bus_free_req && abort_unit == $past(nexus_unit))
        else $error("abort did not clear the unit");
    AST_ABORT_BARE: assert property (abort_nexus |-> $past(nexus_valid) && !unexpected_disc)
        else $error("abort clears without identified unit");
    AST_SECOND_ID: assert property (msg_done && nexus_valid && tk && msg_byte[7] &&
        {msg_byte[5], msg_byte[2:0]} != nexus_unit |=> bus_free_req && unexpected_disc)
        else $error("second identify of other unit kept");
    COV_ABORT: cover property (abort_nexus);
    COV_LONG_EXT: cover property (ext_done && ext_len == 9'h100);
    COV_BAD: cover property (unexpected_disc);
endmodule
bind bmph_top bmph_checker bmph_checker_i (.*);

//--- verif/bmph_initiator.sv
// partner model: initiator driving selection, reselection and message-out bytes
`timescale 1ns/100ps
module bmph_initiator (
    input wire logic clk,
    output logic sel_start,
    output logic resel_start,
    output logic msg_phase,
    output logic msg_valid,
    output logic [7:0] msg_byte
);
    initial begin
        sel_start = 1'b0;
        resel_start = 1'b0;
        msg_phase = 1'b0;
        msg_valid = 1'b0;
        msg_byte = 8'h00;
    end
    // caller picks the opening byte; only bad-opening tests pick a forbidden one
    task automatic select();
        @(negedge clk);
        sel_start = 1'b1;
        msg_phase = 1'b1;
        @(negedge clk);
        sel_start = 1'b0;
    endtask
    // pointers are restored inside the initiator on reconnection; nothing goes on the wire
    task automatic resel();
        @(negedge clk);
        resel_start = 1'b1;
        @(negedge clk);
        resel_start = 1'b0;
    endtask
    task automatic phase();
        @(negedge clk);
        msg_phase = 1'b1;
    endtask
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        msg_valid = 1'b1;
        msg_byte = b;
    endtask
    // released lines show the inverse, never a stale copy
    task automatic idle();
        @(negedge clk);
        msg_valid = 1'b0;
        msg_byte = ~msg_byte;
    endtask
    task automatic fin();
        idle();
        msg_phase = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // args kept below 80h so none looks like an identify
    task automatic send_ext(input logic [7:0] len, input logic [7:0] code);
        int n;
        n = (len == 8'h00) ? 255 : int'(len) - 1;
        send(8'h01);
        send(len);
        send(code);
        for (int i = 0; i < n; i++) send(8'(i) & 8'h7F);
    endtask
endmodule

//--- verif/bmph_tb.sv
// testbench: opening checks, extended layout, identify tracking and abort
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sel_start, resel_start, msg_phase, msg_valid;
    logic [7:0] msg_byte;
    logic [3:0] own_unit;
    logic bus_free_req, unexpected_disc, abort_nexus, ident_in_valid, msg_done, ext_done;
    logic arg_valid, nexus_valid;
    logic [3:0] abort_unit, nexus_unit;
    logic [7:0] ident_in_byte, msg_code, msg_param, ext_code, arg_byte;
    logic [8:0] ext_len;
    bmph_pkg::bmph_xcode_t ext_kind;
    logic [6:0] pl;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int cnt [7];
    bmph_top bmph_top_i (.*);
    bmph_initiator bmph_initiator_i (.*);
    assign pl = {ident_in_valid, arg_valid, abort_nexus, ext_done, msg_done, unexpected_disc,
        bus_free_req};
    always #20 clk = ~clk;
    // pulses tallied mid-cycle, away from the edge that launches them
    always @(negedge clk) begin
        cyc++;
        for (int i = 0; i < 7; i++) cnt[i] += int'(pl[i]);
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cc(input int i, input int e);
        chk($sformatf("pulse count %0d", i), 16'(e), 16'(cnt[i]));
    endtask
    task automatic clr();
        foreach (cnt[i]) cnt[i] = 0;
    endtask
    task automatic s_bad_first();
        logic [7:0] bad [3] = '{8'h00, 8'h20, 8'h01};
        foreach (bad[i]) begin
            clr();
            bmph_initiator_i.select();
            bmph_initiator_i.send(bad[i]);
            bmph_initiator_i.fin();
            cc(0, 1);
            cc(1, 1);
            cc(2, 0);
        end
    endtask
    task automatic s_abort_bare();
        clr();
        bmph_initiator_i.select();
        bmph_initiator_i.send(8'h06);
        bmph_initiator_i.fin();
        bmph_initiator_i.select();
        bmph_initiator_i.send(8'h0C);
        bmph_initiator_i.fin();
        cc(0, 2);
        cc(4, 0);
        cc(1, 0);
        cc(2, 2);
    endtask
    task automatic s_nexus();
        logic [7:0] cd [6] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h45, 8'h90};
        bmph_pkg::bmph_xcode_t kd [6] = '{bmph_pkg::BMPH_X_MODIFY_PTR, bmph_pkg::BMPH_X_SYNC_REQ,
            bmph_pkg::BMPH_X_WIDE_REQ, bmph_pkg::BMPH_X_RESERVED, bmph_pkg::BMPH_X_RESERVED,
            bmph_pkg::BMPH_X_VENDOR};
        clr();
        bmph_initiator_i.select();
        bmph_initiator_i.send(8'hA3);
        bmph_initiator_i.send(8'h20);
        bmph_initiator_i.send(8'h5A);
        bmph_initiator_i.idle();
        chk("msg_param", 16'h5A, 16'(msg_param));
        chk("nexus_unit", 16'hB, 16'(nexus_unit));
        foreach (cd[i]) begin
            bmph_initiator_i.send_ext(8'h03, cd[i]);
            bmph_initiator_i.idle();
            chk("ext_kind", 16'(kd[i]), 16'(ext_kind));
        end
        bmph_initiator_i.send(8'hA3);
        bmph_initiator_i.send(8'h06);
        bmph_initiator_i.fin();
        cc(1, 0);
        cc(4, 1);
        chk("abort_unit", 16'hB, 16'(abort_unit));
        chk("nexus_valid", 16'h0, 16'(nexus_valid));
        cc(3, 6);
        cc(5, 12);
    endtask
    task automatic s_edges();
        clr();
        bmph_initiator_i.select();
        bmph_initiator_i.send(8'h80);
        bmph_initiator_i.send_ext(8'h01, 8'h01);
        bmph_initiator_i.send_ext(8'h00, 8'h80);
        bmph_initiator_i.send(8'h81);
        bmph_initiator_i.fin();
        cc(3, 2);
        cc(5, 255);
        chk("ext_len", 16'h100, 16'(ext_len));
        cc(1, 1);
    endtask
    // phase drop cuts a partial message, then a reset lands mid-message
    task automatic s_cut();
        clr();
        bmph_initiator_i.select();
        bmph_initiator_i.send(8'h80);
        bmph_initiator_i.send(8'h01);
        bmph_initiator_i.send(8'h05);
        bmph_initiator_i.fin();
        bmph_initiator_i.phase();
        bmph_initiator_i.send_ext(8'h01, 8'h03);
        bmph_initiator_i.idle();
        chk("ext_kind", 16'(bmph_pkg::BMPH_X_WIDE_REQ), 16'(ext_kind));
        bmph_initiator_i.send(8'h01);
        bmph_initiator_i.send(8'h04);
        bmph_initiator_i.idle();
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("nexus_valid", 16'h0, 16'(nexus_valid));
        chk("ext_kind", 16'(bmph_pkg::BMPH_X_NONE), 16'(ext_kind));
        clr();
        bmph_initiator_i.select();
        bmph_initiator_i.send(8'h81);
        bmph_initiator_i.send_ext(8'h02, 8'h00);
        bmph_initiator_i.fin();
        cc(3, 1);
        cc(5, 1);
        chk("ext_len", 16'h2, 16'(ext_len));
    endtask
    task automatic s_resel();
        logic [3:0] un [2] = '{4'h5, 4'hA};
        foreach (un[i]) begin
            clr();
            @(negedge clk);
            own_unit = un[i];
            bmph_initiator_i.resel();
            repeat (3) @(negedge clk);
            cc(6, 1);
            chk("ident_in_byte", {8'h00, 4'h8, un[i]}, 16'(ident_in_byte));
        end
    endtask
    initial begin
        own_unit = 4'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        s_bad_first();
        s_abort_bare();
        s_nexus();
        s_edges();
        s_cut();
        s_resel();
        wrap_up();
    end
endmodule
